// *** hdl/bol_burst_seq.sv ***
/*
 * Beat address generator: maps a beat index to the burst address.
 * Assumes start holds column bits 4:2 as taken from the command.
 */
module bol_burst_seq
(
    input  wire logic [2:0] start,
    input  wire logic       bl32,
    input  wire logic       is_write,
    input  wire logic [4:0] idx,
    output logic      [4:0] addr
);
    // ============================================================
    // Address
    // ============================================================
    logic [3:0] base;
    logic       half;

    always_comb
    begin
        // Writes run linearly from the start of their half; reads wrap in 16.
        base = is_write ? 4'h0 : {start[1:0], 2'b00};
        // A 16-beat read ignores bit 4; a write keeps it to pick the upper half.
        half = (is_write || bl32) ? start[2] : 1'b0;
        addr = {half ^ (bl32 & idx[4]), 4'(base + idx[3:0])};
    end
endmodule

// *** hdl/bol_device.sv ***
/*
 * Device end: latency register with two set-point copies, latency wait and
 * burst beat ordering. Assumes the controller keeps its command-bus obligations.
 */
// Added by the designer: the address-and-strobe port.
module bol_device
(
    bol_if.dev                   link,
    input  wire logic            setpoint_write_select,
    input  wire logic            setpoint_operate_select,
    input  wire logic            byte_inversion,
    input  wire logic [1:0]      burst_mode,
    output logic      [5:0]      read_latency,
    output logic      [5:0]      write_latency,
    output logic      [4:0]      read_to_precharge_cycles,
    output logic                 leveling_on
);
    import bol_pkg::*;

    // ============================================================
    // Latency register, one copy per set point
    // ============================================================
    logic [7:0] lat_reg  [2];
    logic [7:0] lat_next [2];
    logic       mode_wr_take;
    logic [7:0] active;
    logic [2:0] rd_code;
    logic [2:0] wr_code;

    // The bus carries column bits 9:2 only, so bits 1:0 are implied zero.
    assign mode_wr_take = link.ca_valid && link.ca_cmd == CMD_MODE_WR;

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_setpoint
            always_comb
            begin
                lat_next[g] = lat_reg[g];
                // Other addresses are not held here and leave the copies alone.
                if (mode_wr_take && link.ca_ma == MA_LATENCY && setpoint_write_select == 1'(g))
                begin
                    lat_next[g] = link.ca_op;
                end
            end

            always_ff @(posedge link.clk or negedge link.arst_n)
            begin
                if (!link.arst_n)
                begin
                    lat_reg[g] <= LAT_RESET;
                end
                else
                begin
                    lat_reg[g] <= lat_next[g];
                end
            end
        end
    endgenerate

    // ============================================================
    // Active latency values
    // ============================================================
    logic [5:0] rd_val;
    logic [5:0] wr_val;
    logic [4:0] rtp_val;
    logic       mode_bl32;

    always_comb
    begin
        active    = lat_reg[setpoint_operate_select];
        rd_code   = active[RDLAT_LSB +: 3];
        wr_code   = active[WRLAT_LSB +: 3];
        rd_val    = byte_inversion ? RDLAT_INV[rd_code] : RDLAT_PLAIN[rd_code];
        wr_val    = active[WRLAT_SEL_BIT] ? WRLAT_B[wr_code] : WRLAT_A[wr_code];
        mode_bl32 = burst_mode == BLM_32;
        rtp_val   = 5'(RTP_TAB[rd_code] + (mode_bl32 ? RTP_BL32_ADD : 5'h00));
    end

    assign read_latency             = rd_val;
    assign write_latency            = wr_val;
    assign read_to_precharge_cycles = rtp_val;
    assign leveling_on              = active[LEV_BIT];

    // ============================================================
    // Command sequencer
    // ============================================================
    bol_state_e  state_reg;
    bol_state_e  state_next;
    logic [5:0]  cnt_reg;
    logic [5:0]  cnt_next;
    logic [4:0]  idx_reg;
    logic [4:0]  idx_next;
    logic        wr_reg;
    logic        wr_next;
    logic        bl32_reg;
    logic        bl32_next;
    logic [7:0]  col_reg;
    logic [7:0]  col_next;
    logic        beat_valid_reg;
    logic        beat_valid_next;
    logic        beat_write_reg;
    logic        beat_write_next;
    logic [9:0]  beat_col_reg;
    logic [9:0]  beat_col_next;
    logic [4:0]  seq_addr;
    logic        cmd_bl32;

    bol_burst_seq u_seq
    (
        .start    (col_reg[2:0]),
        .bl32     (bl32_reg),
        .is_write (wr_reg),
        .idx      (idx_reg),
        .addr     (seq_addr)
    );

    always_comb
    begin
        // Reserved mode code falls back to 16 beats.
        case (burst_mode)
            BLM_32:  cmd_bl32 = 1'b1;
            BLM_OTF: cmd_bl32 = link.ca_bl32;
            default: cmd_bl32 = 1'b0;
        endcase

        state_next      = state_reg;
        cnt_next        = cnt_reg;
        idx_next        = idx_reg;
        wr_next         = wr_reg;
        bl32_next       = bl32_reg;
        col_next        = col_reg;
        beat_valid_next = 1'b0;
        beat_write_next = beat_write_reg;
        beat_col_next   = beat_col_reg;

        case (state_reg)
            ST_IDLE:
            begin
                if (leveling_on)
                begin
                    state_next = ST_LEVEL;
                end
                else if (link.ca_valid && (link.ca_cmd == CMD_RD || link.ca_cmd == CMD_WR))
                begin
                    wr_next    = link.ca_cmd == CMD_WR;
                    bl32_next  = cmd_bl32;
                    col_next   = link.ca_col;
                    cnt_next   = 6'((link.ca_cmd == CMD_WR ? wr_val : rd_val) - 6'h01);
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (cnt_reg == 6'h00)
                begin
                    idx_next   = 5'h00;
                    state_next = ST_BURST;
                end
                else
                begin
                    cnt_next = 6'(cnt_reg - 6'h01);
                end
            end
            ST_BURST:
            begin
                beat_valid_next = 1'b1;
                beat_write_next = wr_reg;
                beat_col_next   = {col_reg[7:3], seq_addr};
                if (idx_reg == (bl32_reg ? LAST_BL32 : LAST_BL16))
                begin
                    state_next = ST_IDLE;
                end
                else
                begin
                    idx_next = 5'(idx_reg + 5'h01);
                end
            end
            ST_LEVEL:
            begin
                // Only a register write may arrive here; it is applied above.
                if (!leveling_on)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge link.clk or negedge link.arst_n)
    begin
        if (!link.arst_n)
        begin
            state_reg      <= ST_IDLE;
            cnt_reg        <= 6'h00;
            idx_reg        <= 5'h00;
            wr_reg         <= 1'b0;
            bl32_reg       <= 1'b0;
            col_reg        <= 8'h00;
            beat_valid_reg <= 1'b0;
            beat_write_reg <= 1'b0;
            beat_col_reg   <= 10'h000;
        end
        else
        begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            idx_reg        <= idx_next;
            wr_reg         <= wr_next;
            bl32_reg       <= bl32_next;
            col_reg        <= col_next;
            beat_valid_reg <= beat_valid_next;
            beat_write_reg <= beat_write_next;
            beat_col_reg   <= beat_col_next;
        end
    end

    assign link.dev_busy   = state_reg == ST_WAIT || state_reg == ST_BURST;
    assign link.beat_valid = beat_valid_reg;
    assign link.beat_write = beat_write_reg;
    assign link.beat_col   = beat_col_reg;
endmodule

// *** hdl/bol_host.sv ***
/*
 * Controller end: software registers that compose and issue column and
 * register-write commands. Assumes the device answers over bol_if.
 */
module bol_host
(
    bol_if.ctl                   link,
    input  wire logic [3:0]      sw_addr,
    input  wire logic [31:0]     sw_wdata,
    input  wire logic            sw_wr,
    input  wire logic            sw_rd,
    output logic      [31:0]     sw_rdata
);
    import bol_pkg::*;

    // ============================================================
    // Registers
    // ============================================================
    logic [10:0] column_reg;
    logic [10:0] column_next;
    logic [13:0] mode_reg;
    logic [13:0] mode_next;
    logic        lev_reg;
    logic        lev_next;
    logic        refused_reg;
    logic        refused_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        ca_valid_reg;
    logic        ca_valid_next;
    bol_cmd_e    ca_cmd_reg;
    bol_cmd_e    ca_cmd_next;
    logic [7:0]  ca_col_reg;
    logic [7:0]  ca_col_next;
    logic        ca_bl32_reg;
    logic        ca_bl32_next;
    logic [5:0]  ca_ma_reg;
    logic [5:0]  ca_ma_next;
    logic [7:0]  ca_op_reg;
    logic [7:0]  ca_op_next;

    bol_cmd_e    req;
    logic        busy;
    logic        clears_lev;
    logic        allowed;
    logic        go;
    logic        bl32;
    logic [7:0]  col;

    always_comb
    begin
        req        = bol_cmd_e'(sw_wdata[1:0]);
        busy       = link.dev_busy || ca_valid_reg;
        bl32       = column_reg[COLUMN_BL32_BIT];
        clears_lev = req == CMD_MODE_WR && mode_reg[MODE_MA_LSB +: 6] == MA_LATENCY && !mode_reg[LEV_BIT];
        allowed    = !busy && req != CMD_NOP && (!lev_reg || clears_lev);
        go         = sw_wr && sw_addr == REG_ISSUE;

        // Bits 1:0 are dropped; writes zero 3:2, and 4 as well for 32 beats.
        col = column_reg[9:2];
        if (req == CMD_WR)
        begin
            col[1:0] = 2'b00;
            if (bl32)
            begin
                col[2] = 1'b0;
            end
        end

        column_next   = column_reg;
        mode_next     = mode_reg;
        lev_next      = lev_reg;
        refused_next  = refused_reg;
        ca_valid_next = 1'b0;
        ca_cmd_next   = ca_cmd_reg;
        ca_col_next   = ca_col_reg;
        ca_bl32_next  = ca_bl32_reg;
        ca_ma_next    = ca_ma_reg;
        ca_op_next    = ca_op_reg;

        if (sw_wr && sw_addr == REG_COLUMN)
        begin
            column_next = sw_wdata[10:0];
        end
        if (sw_wr && sw_addr == REG_MODE)
        begin
            mode_next = sw_wdata[13:0];
        end
        if (sw_wr && sw_addr == REG_STATUS && sw_wdata[STAT_REFUSED_BIT])
        begin
            refused_next = 1'b0;
        end
        if (go && allowed)
        begin
            ca_valid_next = 1'b1;
            ca_cmd_next   = req;
            ca_col_next   = col;
            ca_bl32_next  = bl32;
            ca_ma_next    = mode_reg[MODE_MA_LSB +: 6];
            ca_op_next    = mode_reg[7:0];
            if (req == CMD_MODE_WR && mode_reg[MODE_MA_LSB +: 6] == MA_LATENCY)
            begin
                lev_next = mode_reg[LEV_BIT];
            end
        end
        else if (go)
        begin
            refused_next = 1'b1;
        end

        rdata_next = 32'h0000_0000;
        if (sw_rd)
        begin
            case (sw_addr)
                REG_COLUMN: rdata_next = {21'h000000, column_reg};
                REG_MODE:   rdata_next = {18'h00000, mode_reg};
                REG_STATUS: rdata_next = {29'h00000000, refused_reg, lev_reg, busy};
                default:    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge link.clk or negedge link.arst_n)
    begin
        if (!link.arst_n)
        begin
            column_reg   <= 11'h000;
            mode_reg     <= 14'h0000;
            lev_reg      <= 1'b0;
            refused_reg  <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            ca_valid_reg <= 1'b0;
            ca_cmd_reg   <= CMD_NOP;
            ca_col_reg   <= 8'h00;
            ca_bl32_reg  <= 1'b0;
            ca_ma_reg    <= 6'h00;
            ca_op_reg    <= 8'h00;
        end
        else
        begin
            column_reg   <= column_next;
            mode_reg     <= mode_next;
            lev_reg      <= lev_next;
            refused_reg  <= refused_next;
            rdata_reg    <= rdata_next;
            ca_valid_reg <= ca_valid_next;
            ca_cmd_reg   <= ca_cmd_next;
            ca_col_reg   <= ca_col_next;
            ca_bl32_reg  <= ca_bl32_next;
            ca_ma_reg    <= ca_ma_next;
            ca_op_reg    <= ca_op_next;
        end
    end

    assign sw_rdata      = rdata_reg;
    assign link.ca_valid = ca_valid_reg;
    assign link.ca_cmd   = ca_cmd_reg;
    assign link.ca_col   = ca_col_reg;
    assign link.ca_bl32  = ca_bl32_reg;
    assign link.ca_ma    = ca_ma_reg;
    assign link.ca_op    = ca_op_reg;
endmodule

// *** hdl/bol_if.sv ***
/*
 * Command/address and beat link between the memory controller and the device.
 * Assumes both ends share clk and arst_n; the testbench instantiates it.
 */
interface bol_if
(
    input wire logic clk,
    input wire logic arst_n
);
    import bol_pkg::*;

    logic                  ca_valid;
    bol_cmd_e              ca_cmd;
    logic [CA_COL_W-1:0]   ca_col;
    logic                  ca_bl32;
    logic [5:0]            ca_ma;
    logic [7:0]            ca_op;
    logic                  dev_busy;
    logic                  beat_valid;
    logic                  beat_write;
    logic [COL_W-1:0]      beat_col;

    modport dev
    (
        input  clk, arst_n, ca_valid, ca_cmd, ca_col, ca_bl32, ca_ma, ca_op,
        output dev_busy, beat_valid, beat_write, beat_col
    );

    modport ctl
    (
        input  clk, arst_n, dev_busy, beat_valid, beat_write, beat_col,
        output ca_valid, ca_cmd, ca_col, ca_bl32, ca_ma, ca_op
    );
endinterface

// *** hdl/bol_pkg.sv ***
/*
 * Shared constants and types for the burst order and latency configuration pair.
 * Assumes a single clock and an active-low asynchronous reset at both ends.
 */
package bol_pkg;

    // ============================================================
    // Command bus
    // ============================================================
    typedef enum logic [1:0]
    {
        CMD_NOP     = 2'h0,
        CMD_RD      = 2'h1,
        CMD_WR      = 2'h2,
        CMD_MODE_WR = 2'h3
    } bol_cmd_e;

    localparam int        COL_W       = 10;
    localparam int        CA_COL_W    = 8;
    localparam logic [5:0] MA_LATENCY = 6'h02;

    // ============================================================
    // Latency register fields and reset value
    // ============================================================
    localparam int        RDLAT_LSB     = 0;
    localparam int        WRLAT_LSB     = 3;
    localparam int        WRLAT_SEL_BIT = 6;
    localparam int        LEV_BIT     = 7;
    localparam logic [7:0] LAT_RESET  = 8'h00;

    // ============================================================
    // Burst length
    // ============================================================
    localparam logic [1:0] BLM_16     = 2'h0;
    localparam logic [1:0] BLM_32     = 2'h1;
    localparam logic [1:0] BLM_OTF    = 2'h2;
    localparam logic [4:0] LAST_BL16  = 5'h0F;
    localparam logic [4:0] LAST_BL32  = 5'h1F;
    localparam logic [4:0] RTP_BL32_ADD = 5'h08;

    // ============================================================
    // Latency tables, indexed by the 3-bit code
    // ============================================================
    localparam logic [5:0] RDLAT_PLAIN [0:7] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
    localparam logic [5:0] RDLAT_INV   [0:7] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
    localparam logic [4:0] RTP_TAB     [0:7] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10};
    localparam logic [5:0] WRLAT_A     [0:7] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
    localparam logic [5:0] WRLAT_B     [0:7] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};

    // ============================================================
    // Controller software registers
    // ============================================================
    localparam logic [3:0] REG_COLUMN = 4'h0;
    localparam logic [3:0] REG_MODE   = 4'h1;
    localparam logic [3:0] REG_ISSUE  = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam int        COLUMN_BL32_BIT = 10;
    localparam int        MODE_MA_LSB     = 8;
    localparam int        STAT_BUSY_BIT   = 0;
    localparam int        STAT_LEV_BIT    = 1;
    localparam int        STAT_REFUSED_BIT = 2;

    // ============================================================
    // Device sequencer states
    // ============================================================
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_BURST = 2'b11,
        ST_LEVEL = 2'b10
    } bol_state_e;

endpackage

// *** verif/bol_sva.sv ***
/*
 * Checker for the command and beat link between the two ends.
 * Assumes the bench connects it beside bol_if, every signal by name.
 */
module bol_sva
    import bol_pkg::*;
(
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic                ca_valid,
    input wire bol_cmd_e            ca_cmd,
    input wire logic [CA_COL_W-1:0] ca_col,
    input wire logic                dev_busy,
    input wire logic                beat_valid,
    input wire logic                beat_write,
    input wire logic [COL_W-1:0]    beat_col
);
    // ============================================================
    // Link properties
    // ============================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic take;
    assign take = ca_valid && !dev_busy && (ca_cmd == CMD_RD || ca_cmd == CMD_WR);

    a_ca_pulse: assert property (ca_valid |=> !ca_valid)
        else $error("command strobe held beyond one cycle");
    a_ca_when_idle: assert property (ca_valid |-> !dev_busy)
        else $error("command sent while device busy");
    a_wr_col_low: assert property (ca_valid && ca_cmd == CMD_WR |-> ca_col[1:0] == 2'h0)
        else $error("write command with column bits 3:2 set");
    // The shortest latency is four cycles, so nothing may show for five cycles.
    a_beat_quiet: assert property (take |=> !beat_valid [*5])
        else $error("beat earlier than the shortest latency");
    a_beat_within: assert property (take |-> ##[6:42] beat_valid)
        else $error("no beat within the longest latency");
    a_burst_sixteen: assert property ($rose(beat_valid) |-> beat_valid [*8] ##1 beat_valid [*8])
        else $error("burst shorter than sixteen beats");
    a_beat_step: assert property (beat_valid && $past(beat_valid)
        |-> beat_col[3:0] == $past(beat_col[3:0]) + 4'h1)
        else $error("beat address did not step by one within the group");
    a_start_align: assert property ($rose(beat_valid) |-> beat_col[1:0] == 2'h0)
        else $error("burst start not on a four-beat boundary");
    a_write_start: assert property ($rose(beat_valid) && beat_write |-> beat_col[3:0] == 4'h0)
        else $error("write burst not starting on a half boundary");

    c_read: cover property ($rose(beat_valid) && !beat_write);
    c_write: cover property ($rose(beat_valid) && beat_write);
    c_mode_write: cover property (ca_valid && ca_cmd == CMD_MODE_WR);
endmodule

// *** verif/burst_order_latency_config_tb.sv ***
/*
 * Self-checking bench for the controller and device ends joined by bol_if.
 * Assumes software reaches the controller through its plain register port.
 */
module burst_order_latency_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bol_pkg::*;

    logic        clk;
    logic        arst_n   = 1'b0;
    logic [3:0]  sw_addr  = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr    = 1'b0;
    logic        sw_rd    = 1'b0;
    logic [31:0] sw_rdata;
    logic        wsel     = 1'b0;
    logic        osel     = 1'b0;
    logic        inv      = 1'b0;
    logic [1:0]  bmode    = 2'h2;
    logic [5:0]  rd_lat;
    logic [5:0]  wr_lat;
    logic [4:0]  rtp;
    logic        lev;
    int          err_count = 0;
    int          checked   = 0;
    int          cyc       = 0;

    bol_if link (.clk(clk), .arst_n(arst_n));
    bol_host u_bol_host (.link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
                         .sw_rdata(sw_rdata));
    bol_device u_bol_device (.link(link), .setpoint_write_select(wsel), .setpoint_operate_select(osel),
                             .byte_inversion(inv), .burst_mode(bmode), .read_latency(rd_lat), .write_latency(wr_lat),
                             .read_to_precharge_cycles(rtp), .leveling_on(lev));
    bol_sva u_bol_sva (.clk(clk), .arst_n(arst_n), .ca_valid(link.ca_valid), .ca_cmd(link.ca_cmd),
                       .ca_col(link.ca_col), .dev_busy(link.dev_busy), .beat_valid(link.beat_valid),
                       .beat_write(link.beat_write), .beat_col(link.beat_col));

    // ============================================================
    // Bus tasks
    // ============================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr    <= 1'b0;
    endtask

    task automatic sw_read(input logic [3:0] a);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd   <= 1'b0;
        #1;
    endtask

    // Outputs follow the register copy combinationally, so three cycles cover the command path.
    task automatic mode_write(input logic [5:0] ma, input logic [7:0] op);
        sw_write(REG_MODE, {18'h0, ma, op});
        sw_write(REG_ISSUE, 32'h3);
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic burst(input logic wr, input logic [9:0] col, input logic b32, input int lat);
        int         t;
        logic [4:0] a;
        sw_write(REG_COLUMN, {21'h0, b32, col});
        sw_write(REG_ISSUE, {30'h0, wr, ~wr});
        t = 0;
        do
        begin
            @(posedge clk);
            #1;
            t++;
        end
        while (link.beat_valid !== 1'b1 && t < 60);
        // Taken one edge after the strobe, the first beat follows latency plus one edges later.
        chk(t, lat + 2);
        for (int i = 0; i < (b32 ? 32 : 16); i++)
        begin
            if (i > 0)
            begin
                @(posedge clk);
                #1;
            end
            a = wr ? {col[4], 4'h0} + 5'(i) : {b32 & (col[4] ^ (i >= 16)), col[3:0] + 4'(i)};
            chk({link.beat_write, link.beat_valid, link.beat_col}, {wr, 1'b1, col[9:5], a});
        end
        @(posedge clk);
        #1;
        chk(link.beat_valid, 1'b0);
        repeat (3) @(posedge clk);
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_reset();
        sw_read(4'hF);
        chk(sw_rdata, 32'h0);
        chk({lev, rtp, wr_lat, rd_lat}, {1'b0, 5'h08, 6'h04, 6'h06});
        mode_write(6'h03, 8'hFF);
        chk({lev, rtp, wr_lat, rd_lat}, {1'b0, 5'h08, 6'h04, 6'h06});
        $display("test reset done");
    endtask

    task automatic t_latency();
        logic [5:0] rla [8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
        logic [5:0] rlb [8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
        logic [5:0] wla [8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
        logic [5:0] wlb [8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
        logic [4:0] rtt [8] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10};
        for (int c = 0; c < 8; c++)
        begin
            mode_write(6'h02, {2'b00, 3'(c), 3'(c)});
            chk({rtp, wr_lat, rd_lat}, {rtt[c], wla[c], rla[c]});
            mode_write(6'h02, {2'b01, 3'(c), 3'(c)});
            @(posedge clk);
            inv <= 1'b1;
            @(posedge clk);
            #1;
            chk({rtp, wr_lat, rd_lat}, {rtt[c], wlb[c], rlb[c]});
            @(posedge clk);
            inv <= 1'b0;
        end
        bmode <= 2'h1;
        @(posedge clk);
        #1;
        chk(rtp, 5'h18);
        @(posedge clk);
        bmode <= 2'h3;
        @(posedge clk);
        #1;
        chk(rtp, 5'h10);
        @(posedge clk);
        bmode <= 2'h2;
        mode_write(6'h02, 8'h00);
        $display("test latency done");
    endtask

    task automatic t_setpoint();
        @(posedge clk);
        osel <= 1'b1;
        wsel <= 1'b1;
        @(posedge clk);
        #1;
        chk({lev, wr_lat, rd_lat}, {1'b0, 6'h04, 6'h06});
        @(posedge clk);
        osel <= 1'b0;
        mode_write(6'h02, 8'h09);
        chk({wr_lat, rd_lat}, {6'h04, 6'h06});
        @(posedge clk);
        osel <= 1'b1;
        wsel <= 1'b0;
        mode_write(6'h02, 8'h3F);
        chk({wr_lat, rd_lat}, {6'h06, 6'h0A});
        @(posedge clk);
        osel <= 1'b0;
        @(posedge clk);
        #1;
        chk({wr_lat, rd_lat}, {6'h12, 6'h24});
        mode_write(6'h02, 8'h00);
        $display("test setpoint done");
    endtask

    task automatic t_level();
        mode_write(6'h02, 8'h80);
        chk(lev, 1'b1);
        sw_write(REG_COLUMN, 32'h0);
        sw_write(REG_ISSUE, 32'h1);
        repeat (8) @(posedge clk);
        sw_read(REG_STATUS);
        chk({link.dev_busy, sw_rdata[2:1]}, 3'b011);
        sw_write(REG_STATUS, 32'h4);
        mode_write(6'h02, 8'h00);
        sw_read(REG_STATUS);
        chk({lev, sw_rdata[2:0]}, 4'h0);
        $display("test leveling done");
    endtask

    task automatic t_bursts();
        burst(1'b0, 10'h2BC, 1'b0, 6);
        burst(1'b0, 10'h014, 1'b1, 6);
        burst(1'b1, 10'h1F0, 1'b0, 4);
        burst(1'b1, 10'h000, 1'b1, 4);
        mode_write(6'h02, 8'h0B);
        burst(1'b0, 10'h008, 1'b0, 20);
        burst(1'b1, 10'h000, 1'b0, 6);
        $display("test bursts done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ============================================================
    // Clock, timeout and main sequence
    // ============================================================
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            final_report();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_latency();
        t_setpoint();
        t_level();
        t_bursts();
        final_report();
    end
endmodule
